/* File: design/link_cycle_pkg.sv */
package link_cycle_pkg;
  localparam logic [7:0] LINK_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] CYCLE_TIMER_OFFSET = 8'h10;
  localparam logic [31:0] LINK_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CYCLE_TIMER_RESET = 32'h00000000;
  localparam int LAST_ACK_BIT = 30;
  localparam int PHY_LINK_RESET_BIT = 18;
  localparam int STRICT_ISO_BIT = 12;
  localparam int GEN_EN_BIT = 11;
  localparam int EXT_SELECT_BIT = 10;
  localparam int OFFSET_EN_BIT = 9;
  localparam int TX_IDLE_BIT = 6;
  localparam int ROOT_BIT = 5;
  localparam int BUSY_PHASE_BIT = 4;
  localparam int OFFSET_LSB = 0;
  localparam int OFFSET_W = 12;
  localparam int COUNT_LSB = 12;
  localparam int COUNT_W = 13;
  localparam int SECONDS_LSB = 25;
  localparam int SECONDS_W = 7;
  localparam logic [11:0] OFFSET_LAST = 12'hbff;
  localparam logic [12:0] COUNT_LAST = 13'h1f3f;
endpackage

/* File: design/cycle_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module cycle_timer
  import link_cycle_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic count_en,
  input wire logic ext_select,
  input wire logic ext_edge,
  input wire logic load,
  input wire logic [31:0] load_data,
  output logic [31:0] value,
  output logic count_inc
);
  logic [31:0] next_value;
  logic [OFFSET_W-1:0] offset;
  logic [COUNT_W-1:0] count;
  logic [SECONDS_W-1:0] seconds;
  logic bump;

  assign offset = value[OFFSET_LSB +: OFFSET_W];
  assign count = value[COUNT_LSB +: COUNT_W];
  assign seconds = value[SECONDS_LSB +: SECONDS_W];

  // With counting off the timer is a plain host register for firmware tests.
  always_comb begin
    next_value = value;
    bump = 1'b0;
    if (load && !count_en) begin
      next_value = load_data;
    end else if (count_en) begin
      if (ext_select) begin
        next_value[OFFSET_LSB +: OFFSET_W] = offset + 12'h001;
        if (ext_edge) begin
          next_value[OFFSET_LSB +: OFFSET_W] = '0;
          bump = 1'b1;
        end
      end else if (offset == OFFSET_LAST) begin
        next_value[OFFSET_LSB +: OFFSET_W] = '0;
        bump = 1'b1;
      end else begin
        next_value[OFFSET_LSB +: OFFSET_W] = offset + 12'h001;
      end
      if (bump) begin
        if (count == COUNT_LAST) begin
          next_value[COUNT_LSB +: COUNT_W] = '0;
          next_value[SECONDS_LSB +: SECONDS_W] = seconds + 7'h01;
        end else begin
          next_value[COUNT_LSB +: COUNT_W] = count + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= CYCLE_TIMER_RESET;
      count_inc <= 1'b0;
    end else begin
      value <= next_value;
      count_inc <= bump;
    end
  end
endmodule
`default_nettype wire

/* File: design/link_cycle_control.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - Interface reset bit clears itself when done.
// - Strict bit rejects isochronous packets outside cycles.
// - Generator plus root sends start per count.
// - Cycle timeout disables generator; software rearms it.
// - External select: input edge bumps count, clears offset.
// - Otherwise count bumps on offset rollover.
// - Offset counts when enabled; else timer plain.
// - Status bit six shows transmitter idle.
// - Status bit five shows root after self-ID.
// - Status bit four shows next busy phase.
// - Bit thirty holds last async transmit ack.
module link_cycle_control
  import link_cycle_pkg::*;
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [31:0] HOST_WDATA,
  output logic [31:0] HOST_RDATA,
  input wire logic EXTERNAL_CYCLE_INPUT,
  input wire logic CYCLE_TIMEOUT,
  input wire logic TRANSMITTER_IDLE,
  input wire logic ROOT_NODE,
  input wire logic SELF_ID_DONE,
  input wire logic NEXT_BUSY_PHASE,
  input wire logic ASYNC_ACK_VALID,
  input wire logic ASYNC_ACK,
  input wire logic ISO_PKT_VALID,
  input wire logic ISO_IN_WINDOW,
  output logic ISO_PKT_ACCEPT,
  output logic CYCLE_START_REQ,
  output logic PHY_LINK_RESET,
  input wire logic PHY_LINK_RESET_DONE
);
  ////////////////////////////////////////////////////////////////////////////
  logic strict_iso;
  logic gen_en;
  logic ext_select;
  logic offset_en;
  logic if_reset;
  logic next_strict_iso;
  logic next_gen_en;
  logic next_ext_select;
  logic next_offset_en;
  logic next_if_reset;

  logic root;
  logic last_ack;
  logic next_root;
  logic next_last_ack;

  logic ext_prev;
  logic next_ext_prev;
  logic ext_edge;
  logic next_start_req;

  logic ctrl_wr;
  logic timer_wr;
  logic reset_req;
  logic rd_ctrl;
  logic rd_timer;
  logic [31:0] ctrl_image;
  logic [31:0] next_rdata;
  logic [31:0] timer_value;
  logic count_inc;

  ////////////////////////////////////////////////////////////////////////////
  // One offset compare serves both the write and the read decode.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  assign ctrl_wr = HOST_WR && hit(HOST_ADDR, LINK_CTRL_OFFSET);
  assign timer_wr = HOST_WR && hit(HOST_ADDR, CYCLE_TIMER_OFFSET);
  assign reset_req = ctrl_wr && HOST_WDATA[PHY_LINK_RESET_BIT];
  assign rd_ctrl = HOST_RD && hit(HOST_ADDR, LINK_CTRL_OFFSET);
  assign rd_timer = HOST_RD && hit(HOST_ADDR, CYCLE_TIMER_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Host loads reach the timer only while its counting is off.
  assign ext_edge = EXTERNAL_CYCLE_INPUT && !ext_prev;

  cycle_timer u_timer (
    .clk(MCLK),
    .arst_n(ARST_N),
    .count_en(offset_en),
    .ext_select(ext_select),
    .ext_edge(ext_edge),
    .load(timer_wr),
    .load_data(HOST_WDATA),
    .value(timer_value),
    .count_inc(count_inc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Packets outside the cycle window pass only with strict filtering off.
  assign ISO_PKT_ACCEPT = ISO_PKT_VALID
    && (!strict_iso || ISO_IN_WINDOW);
  assign PHY_LINK_RESET = if_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Host-written control bits.
  always_comb begin
    next_strict_iso = strict_iso;
    next_gen_en = gen_en;
    next_ext_select = ext_select;
    next_offset_en = offset_en;
    next_if_reset = if_reset;
    if (ctrl_wr) begin
      next_strict_iso = HOST_WDATA[STRICT_ISO_BIT];
      next_gen_en = HOST_WDATA[GEN_EN_BIT];
      next_ext_select = HOST_WDATA[EXT_SELECT_BIT];
      next_offset_en = HOST_WDATA[OFFSET_EN_BIT];
    end
    if (reset_req) begin
      next_if_reset = 1'b1;
    end
    // A timeout wins over a same-cycle write so a stalled master stays off.
    if (CYCLE_TIMEOUT) begin
      next_gen_en = 1'b0;
    end
    if (if_reset && PHY_LINK_RESET_DONE) begin
      next_if_reset = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strict_iso <= LINK_CTRL_RESET[STRICT_ISO_BIT];
      gen_en <= LINK_CTRL_RESET[GEN_EN_BIT];
      ext_select <= LINK_CTRL_RESET[EXT_SELECT_BIT];
      offset_en <= LINK_CTRL_RESET[OFFSET_EN_BIT];
      if_reset <= LINK_CTRL_RESET[PHY_LINK_RESET_BIT];
    end else begin
      strict_iso <= next_strict_iso;
      gen_en <= next_gen_en;
      ext_select <= next_ext_select;
      offset_en <= next_offset_en;
      if_reset <= next_if_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status captured from the link core.
  always_comb begin
    next_root = root;
    next_last_ack = last_ack;
    if (SELF_ID_DONE) begin
      next_root = ROOT_NODE;
    end
    if (ASYNC_ACK_VALID) begin
      next_last_ack = ASYNC_ACK;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      root <= LINK_CTRL_RESET[ROOT_BIT];
      last_ack <= LINK_CTRL_RESET[LAST_ACK_BIT];
    end else begin
      root <= next_root;
      last_ack <= next_last_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The edge memory clears at reset; counting is off then, so no false edge.
  always_comb begin
    next_ext_prev = EXTERNAL_CYCLE_INPUT;
    next_start_req = gen_en && root && count_inc;
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_prev <= 1'b0;
      CYCLE_START_REQ <= 1'b0;
    end else begin
      ext_prev <= next_ext_prev;
      CYCLE_START_REQ <= next_start_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Image of the control word; bits outside this block read as zero.
  always_comb begin
    ctrl_image = '0;
    ctrl_image[LAST_ACK_BIT] = last_ack;
    ctrl_image[PHY_LINK_RESET_BIT] = if_reset;
    ctrl_image[STRICT_ISO_BIT] = strict_iso;
    ctrl_image[GEN_EN_BIT] = gen_en;
    ctrl_image[EXT_SELECT_BIT] = ext_select;
    ctrl_image[OFFSET_EN_BIT] = offset_en;
    ctrl_image[TX_IDLE_BIT] = TRANSMITTER_IDLE;
    ctrl_image[ROOT_BIT] = root;
    ctrl_image[BUSY_PHASE_BIT] = NEXT_BUSY_PHASE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered; unmapped offsets read as zero.
  always_comb begin
    next_rdata = HOST_RDATA;
    if (rd_ctrl) begin
      next_rdata = ctrl_image;
    end else if (rd_timer) begin
      next_rdata = timer_value;
    end else if (HOST_RD) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_RDATA <= '0;
    end else begin
      HOST_RDATA <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: dv/bus_node_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_node_model #(parameter int LAT = 3) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_req,
  output logic reset_done
);
  int n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n <= 0;
      reset_done <= 1'b0;
    end else begin
      n <= reset_req ? n + 1 : 0;
      reset_done <= reset_req && n == LAT;
    end
  end
endmodule
`default_nettype wire

/* File: dv/link_cycle_control_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module link_cycle_control_properties (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [31:0] HOST_RDATA,
  input wire logic TRANSMITTER_IDLE,
  input wire logic NEXT_BUSY_PHASE,
  input wire logic ASYNC_ACK_VALID,
  input wire logic ASYNC_ACK,
  input wire logic ISO_PKT_VALID,
  input wire logic ISO_IN_WINDOW,
  input wire logic ISO_PKT_ACCEPT,
  input wire logic CYCLE_START_REQ,
  input wire logic CYCLE_TIMEOUT,
  input wire logic PHY_LINK_RESET,
  input wire logic PHY_LINK_RESET_DONE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  wire logic rd_ctl = HOST_RD && HOST_ADDR == 8'h04;
  sequence ack_then_read;
    ASYNC_ACK_VALID ##1 (rd_ctl && !ASYNC_ACK_VALID);
  endsequence
  chk_iso_window_ok: assert property (ISO_PKT_VALID && ISO_IN_WINDOW
    |-> ISO_PKT_ACCEPT) else $error("packet refused");
  chk_iso_needs_valid: assert property (ISO_PKT_ACCEPT
    |-> ISO_PKT_VALID) else $error("accept without packet");
  chk_start_one_cycle: assert property (CYCLE_START_REQ
    |=> !CYCLE_START_REQ) else $error("start too long");
  chk_timeout_stops_start: assert property (CYCLE_TIMEOUT
    |-> ##2 !CYCLE_START_REQ [*8]) else $error("start after timeout");
  chk_reset_ends: assert property (PHY_LINK_RESET && PHY_LINK_RESET_DONE
    |=> !PHY_LINK_RESET) else $error("reset stuck");
  chk_idle_status: assert property (rd_ctl
    |=> HOST_RDATA[6] == $past(TRANSMITTER_IDLE)) else $error("idle bit");
  chk_busy_status: assert property (rd_ctl
    |=> HOST_RDATA[4] == $past(NEXT_BUSY_PHASE)) else $error("busy bit");
  chk_ack_held: assert property (ack_then_read
    |=> HOST_RDATA[30] == $past(ASYNC_ACK, 2)) else $error("ack bit");
endmodule
bind link_cycle_control link_cycle_control_properties i_chk (
  .MCLK(MCLK),
  .ARST_N(ARST_N),
  .HOST_RD(HOST_RD),
  .HOST_ADDR(HOST_ADDR),
  .HOST_RDATA(HOST_RDATA),
  .TRANSMITTER_IDLE(TRANSMITTER_IDLE),
  .NEXT_BUSY_PHASE(NEXT_BUSY_PHASE),
  .ASYNC_ACK_VALID(ASYNC_ACK_VALID),
  .ASYNC_ACK(ASYNC_ACK),
  .ISO_PKT_VALID(ISO_PKT_VALID),
  .ISO_IN_WINDOW(ISO_IN_WINDOW),
  .ISO_PKT_ACCEPT(ISO_PKT_ACCEPT),
  .CYCLE_START_REQ(CYCLE_START_REQ),
  .CYCLE_TIMEOUT(CYCLE_TIMEOUT),
  .PHY_LINK_RESET(PHY_LINK_RESET),
  .PHY_LINK_RESET_DONE(PHY_LINK_RESET_DONE)
);
`default_nettype wire

/* File: dv/link_cycle_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module link_cycle_control_tb_top;
  logic mclk = 0, arst_n = 0, wr = 0, rd = 0, ext = 0, tmo = 0, idle = 0;
  logic root = 0, sid = 0, busy = 0, akv = 0, ak = 0, ipv = 0, iwin = 0;
  logic acc, csr, plr, pld, seen;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  int bad_count = 0, samples_checked = 0;
  always #12.5 mclk = ~mclk;
  link_cycle_control i_link_cycle_control (.MCLK(mclk), .ARST_N(arst_n),
    .HOST_WR(wr), .HOST_RD(rd), .HOST_ADDR(addr), .HOST_WDATA(wdata),
    .HOST_RDATA(rdata), .EXTERNAL_CYCLE_INPUT(ext), .CYCLE_TIMEOUT(tmo),
    .TRANSMITTER_IDLE(idle), .ROOT_NODE(root), .SELF_ID_DONE(sid),
    .NEXT_BUSY_PHASE(busy), .ASYNC_ACK_VALID(akv), .ASYNC_ACK(ak),
    .ISO_PKT_VALID(ipv), .ISO_IN_WINDOW(iwin), .ISO_PKT_ACCEPT(acc),
    .CYCLE_START_REQ(csr), .PHY_LINK_RESET(plr), .PHY_LINK_RESET_DONE(pld));
  bus_node_model i_bus_node_model (.clk(mclk), .arst_n(arst_n),
    .reset_req(plr), .reset_done(pld));
  //////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 0;
    rd <= 0;
    @(posedge mclk);
  endtask
  // Samples on the falling edge so registered pulses have settled.
  task automatic watch(input bit p);
    seen = 0;
    repeat (8) begin
      @(negedge mclk);
      seen |= p ? plr : csr;
    end
    @(posedge mclk);
  endtask
  task automatic t_status();
    {idle, busy, root, sid, akv, ak} <= 6'h3f;
    @(posedge mclk);
    {sid, akv} <= 2'h0;
    bus(0, 8'h04, 0);
    `CHK("ctl", 32'h40000070, rdata)
    {idle, busy, root, akv, ak} <= 5'h2;
    @(posedge mclk);
    akv <= 0;
    bus(0, 8'h04, 0);
    `CHK("ctl2", 32'h00000020, rdata)
  endtask
  task automatic t_iso();
    for (int s = 0; s < 2; s++) begin
      bus(1, 8'h04, s ? 32'h1000 : 32'h0);
      for (int w = 0; w < 2; w++) begin
        ipv <= 1;
        iwin <= w[0];
        @(negedge mclk);
        `CHK("iso", logic'(!s || w), acc)
        @(posedge mclk);
      end
    end
    ipv <= 0;
  endtask
  task automatic t_timer();
    bus(1, 8'h10, 32'h00000bfe);
    bus(0, 8'h10, 0);
    `CHK("tmr", 32'h00000bfe, rdata)
    bus(1, 8'h04, 32'h00000a00);
    watch(0);
    `CHK("roll", 1'b1, seen)
    bus(1, 8'h04, 32'h00000e00);
    ext <= 1;
    watch(0);
    `CHK("ext", 1'b1, seen)
    ext <= 0;
    bus(0, 8'h10, 0);
    `CHK("cnt", 13'h0002, rdata[24:12])
    `CHK("ofs", 12'h007, rdata[11:0])
    bus(1, 8'h10, 32'h12345678);
    bus(0, 8'h10, 0);
    `CHK("lock", 32'h0000200b, rdata)
  endtask
  task automatic t_timeout();
    tmo <= 1;
    @(posedge mclk);
    tmo <= 0;
    ext <= 1;
    watch(0);
    `CHK("tmo", 1'b0, seen)
    ext <= 0;
    bus(1, 8'h04, 32'h00000600);
    bus(1, 8'h04, 32'h00000e00);
    ext <= 1;
    watch(0);
    `CHK("rearm", 1'b1, seen)
    ext <= 0;
  endtask
  // Transmit paths are quiet before the interface reset is asked for.
  task automatic t_phy();
    idle <= 1;
    bus(1, 8'h04, 32'h00040e00);
    watch(1);
    `CHK("rst", 1'b1, seen)
    bus(0, 8'h04, 0);
    `CHK("rst_bit", 1'b0, rdata[18])
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1;
    @(posedge mclk);
    t_status();
    t_iso();
    t_timer();
    t_timeout();
    t_phy();
    report_and_stop();
  end
endmodule
`default_nettype wire
